// File: icr_checker.sv
// checker: port assertions for the indexed configuration register bank
`timescale 1ns/1ps
module icr_checker
	import icr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [15:0] i_io_addr,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [7:0] i_io_wdata,
	input wire logic i_hold_ack,
	input wire logic [7:0] o_io_rdata,
	input wire logic o_io_ack,
	input wire logic o_io_claim,
	input wire logic [2:0] o_backplane_cycle_clocks,
	input wire logic [1:0] o_transfer_wait_count,
	input wire logic o_ext_page_enable,
	input wire logic o_ext_page_hit,
	input wire logic o_hold_ack_internal,
	input wire logic o_fpu_reset_out
);
	logic [4:0] idx;
	logic blk;
	wire wi = i_io_wr && i_io_addr == PORT_INDEX;
	wire wd = i_io_wr && i_io_addr == PORT_DATA;
	// shadow of the pointer and block bit, exact addresses only
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			idx <= RESET_INDEX;
			blk <= 1'b0;
		end else begin
			if (wi)
				idx <= i_io_wdata[4:0];
			if (wd && idx == IDX_COPROC)
				blk <= i_io_wdata[CP_RST_BLK];
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	sequence s_fpu_go;
		i_io_wr && i_io_addr == PORT_FPU_RESET && !blk;
	endsequence
	sequence s_fpu_high;
		o_fpu_reset_out [*4];
	endsequence
	a_index_ack: assert property ((i_io_wr || i_io_rd) && i_io_addr == PORT_INDEX |=>
		o_io_ack && o_io_claim) else $error("index port access not acked");
	a_index_read: assert property (i_io_rd && i_io_addr == PORT_INDEX |=>
		o_io_rdata == {3'h0, $past(idx)}) else $error("index readback wrong");
	a_chip_read: assert property (i_io_rd && i_io_addr == PORT_DATA && idx == IDX_CHIP_ID |=>
		o_io_rdata == {CHIP_CODE, CHIP_REVISION}) else $error("chip id wrong");
	a_fpu_pulse: assert property (s_fpu_go |=> s_fpu_high) else $error("fpu reset pulse short");
	a_fpu_block: assert property (i_io_wr && i_io_addr == PORT_FPU_RESET && blk &&
		!o_fpu_reset_out |=> !o_fpu_reset_out) else $error("blocked fpu reset pulsed");
	a_cycle_len: assert property (wd && idx == IDX_SYSPAR |-> ##2
		o_backplane_cycle_clocks == CYC_BASE - 3'($past(i_io_wdata[4:3], 2)))
		else $error("cycle length wrong");
	a_wait_states: assert property (wd && idx == IDX_DMA |-> ##2
		o_transfer_wait_count == WS_BASE - $past(i_io_wdata[4:3], 2)) else $error("wait count wrong");
	a_ext_hit: assert property ((i_io_wr || i_io_rd) && i_io_addr[15:4] == 12'h048 |=>
		o_ext_page_hit == o_ext_page_enable) else $error("ext page hit wrong");
	a_hold_drop: assert property (!i_hold_ack |=> !o_hold_ack_internal)
		else $error("internal hold ack without hold ack");
endmodule : icr_checker
bind icr_config_regs icr_checker icr_checker_inst (.*);

// File: icr_config_regs.sv
// module: indexed configuration register bank on host i/o space
// Summary of operation
// - thirty-two byte registers at indices 00h to 1fh, read and write except read-only index 0
// - index pointer held here always; port 28h accesses always terminated here
// - write index to 28h, then data to 24h loads selected register
// - reading port 24h returns selected register contents
// - reading port 28h returns five-bit index pointer, upper three bits zero
// - index pointer holds until next write to port 28h
// - reset clears index pointer to 00h
// - index 0 read-only: revision low nibble, chip code high nibble
// - clock register low nibble selects system clock frequency code
// - posting bit lets backplane memory writes end early
// - decode width bit chooses ten or sixteen address bits
// - system control port functions active only while bit 2 set
// - bits 4:3 pick backplane cycle of six down to three clocks
// - parity override bit stops parity errors reaching nmi logic
// - coprocessor register bits report which coprocessors are installed
// - write to port f1h pulses coprocessor reset unless blocked
// - dma bit 0 selects divided or inverted bus clock for dma
// - dma bit 1 enables extended page registers 480h to 48fh
// - flow-through delays internal hold acknowledge until local ready seen
// - dma bits 4:3 set wait states three down to zero
`timescale 1ns/1ps
module icr_config_regs (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [15:0] i_io_addr,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [7:0] i_io_wdata,
	input wire logic i_hold_ack,
	input wire logic i_local_ready_n,
	input wire logic i_parity_err_n,
	output logic [7:0] o_io_rdata,
	output logic o_io_ack,
	output logic o_io_claim,
	output logic [3:0] o_clock_select,
	output logic o_backplane_write_posting,
	output logic o_decode_16bit,
	output logic o_system_control_port_enable,
	output logic [2:0] o_backplane_cycle_clocks,
	output logic o_parity_nmi_req,
	output logic o_coproc_std_present,
	output logic o_coproc_alt_present,
	output logic o_dma_clk_inverted,
	output logic o_ext_page_enable,
	output logic o_ext_page_hit,
	output logic [1:0] o_transfer_wait_count,
	output logic o_hold_ack_internal,
	output logic o_fpu_reset_out
);
	import icr_pkg::*;
	// kinds of host access this bank answers
	typedef enum logic [2:0] {
		ACC_NONE = 3'b000,
		ACC_WR_INDEX = 3'b001,
		ACC_WR_DATA = 3'b010,
		ACC_RD_INDEX = 3'b011,
		ACC_RD_DATA = 3'b100,
		ACC_FPU = 3'b101
	} icr_acc_t;
	// all bank state except the register bytes, which form a memory of their own, and the fpu reset and hold gate submodule state
	typedef struct packed {
		logic [4:0] index;
		logic [7:0] rdata;
		logic ack;
		logic claim;
		logic parity_nmi;
		logic ext_hit;
		logic [3:0] clock_sel;
		logic post;
		logic dec16;
		logic scp_en;
		logic [2:0] cyc_clocks;
		logic std_present;
		logic alt_present;
		logic dma_clk_inv;
		logic ext_en;
		logic [1:0] wait_count;
	} icr_cr_state_t;
	icr_cr_state_t st;
	icr_cr_state_t next_st;
	logic [7:0] regs [0:REG_COUNT-1];
	logic [7:0] clkr;
	logic [7:0] sysp;
	logic [7:0] copr;
	logic [7:0] dmar;
	logic strobe;
	logic hit_data;
	logic hit_index;
	logic hit_fpu;
	logic hit_ext;
	logic wr_index;
	logic wr_data;
	logic rd_index;
	logic rd_data;
	logic fpu_access;
	logic fpu_trigger;
	logic data_we;
	logic [7:0] sel_value;
	icr_acc_t acc;

	// port match honouring the decode width
	function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port,
		input logic wide);
		if (wide) begin
			port_hit = (addr == port);
		end else begin
			port_hit = (addr[9:0] == (port[9:0] & SHORT_DECODE_MASK));
		end
	endfunction : port_hit

	// index zero is wired, never stored, so a stray write cannot corrupt it
	function automatic logic [7:0] reg_value(input logic [4:0] idx, input logic [7:0] raw);
		if (idx == IDX_CHIP_ID) begin
			reg_value = {CHIP_CODE, CHIP_REVISION};
		end else begin
			reg_value = raw;
		end
	endfunction : reg_value

	// two-bit field of a register byte starting at bit lo
	function automatic logic [1:0] field2(input logic [7:0] raw, input int lo);
		field2 = raw[lo +: 2];
	endfunction : field2

	// code zero is the slowest setting, each step one clock shorter
	function automatic logic [2:0] cycle_clocks(input logic [1:0] code);
		cycle_clocks = CYC_BASE - {1'b0, code};
	endfunction : cycle_clocks

	function automatic logic [1:0] wait_states(input logic [1:0] code);
		wait_states = WS_BASE - code;
	endfunction : wait_states

	// one kind per strobe; the three ports never overlap, so the order is moot
	function automatic icr_acc_t access_kind(input logic w_idx, input logic w_dat,
		input logic r_idx, input logic r_dat, input logic fpu);
		if (w_idx) begin
			access_kind = ACC_WR_INDEX;
		end else if (w_dat) begin
			access_kind = ACC_WR_DATA;
		end else if (r_idx) begin
			access_kind = ACC_RD_INDEX;
		end else if (r_dat) begin
			access_kind = ACC_RD_DATA;
		end else if (fpu) begin
			access_kind = ACC_FPU;
		end else begin
			access_kind = ACC_NONE;
		end
	endfunction : access_kind

	// everything idle, timing outputs at their slowest settings
	function automatic icr_cr_state_t reset_state();
		reset_state = '0;
		reset_state.index = RESET_INDEX;
		reset_state.rdata = RESET_BYTE;
		reset_state.ack = 1'b0;
		reset_state.claim = 1'b0;
		reset_state.parity_nmi = 1'b0;
		reset_state.ext_hit = 1'b0;
		reset_state.clock_sel = 4'h0;
		reset_state.post = 1'b0;
		reset_state.dec16 = 1'b0;
		reset_state.scp_en = 1'b0;
		reset_state.cyc_clocks = CYC_BASE;
		reset_state.std_present = 1'b0;
		reset_state.alt_present = 1'b0;
		reset_state.dma_clk_inv = 1'b0;
		reset_state.ext_en = 1'b0;
		reset_state.wait_count = WS_BASE;
	endfunction : reset_state

	// register bytes behind the outputs
	assign clkr = regs[IDX_CLOCK];
	assign sysp = regs[IDX_SYSPAR];
	assign copr = regs[IDX_COPROC];
	assign dmar = regs[IDX_DMA];

	// address decode; only the data, index and fpu reset ports are answered here
	always_comb begin
		hit_data = port_hit(i_io_addr, PORT_DATA, sysp[SP_DEC16]);
		hit_index = port_hit(i_io_addr, PORT_INDEX, sysp[SP_DEC16]);
		hit_fpu = port_hit(i_io_addr, PORT_FPU_RESET, sysp[SP_DEC16]);
		hit_ext = (i_io_addr >= EXT_PAGE_BASE) && (i_io_addr <= EXT_PAGE_LAST);
	end

	// strobes qualified by the decode
	always_comb begin
		strobe = i_io_wr || i_io_rd;
		wr_index = i_io_wr && hit_index;
		wr_data = i_io_wr && hit_data;
		rd_index = i_io_rd && hit_index;
		rd_data = i_io_rd && hit_data;
		fpu_access = strobe && hit_fpu;
		fpu_trigger = i_io_wr && hit_fpu;
		acc = access_kind(wr_index, wr_data, rd_index, rd_data, fpu_access);
		data_we = (acc == ACC_WR_DATA) && (st.index != IDX_CHIP_ID);
		sel_value = reg_value(st.index, regs[st.index]);
	end

	// register memory; the pointer selects the byte a data write lands in
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= RESET_BYTE;
			end
		end else if (data_we) begin
			regs[st.index] <= i_io_wdata;
		end
	end

	always_comb begin
		next_st = st;
		// every access to the three ports is answered for one cycle
		case (acc)
			ACC_WR_INDEX: begin
				next_st.ack = 1'b1;
				next_st.claim = 1'b1;
				next_st.index = i_io_wdata[4:0];
			end
			ACC_WR_DATA: begin
				next_st.ack = 1'b1;
				next_st.claim = 1'b1;
			end
			ACC_RD_INDEX: begin
				next_st.ack = 1'b1;
				next_st.claim = 1'b1;
				next_st.rdata = {3'h0, st.index};
			end
			ACC_RD_DATA: begin
				next_st.ack = 1'b1;
				next_st.claim = 1'b1;
				next_st.rdata = sel_value;
			end
			ACC_FPU: begin
				next_st.ack = 1'b1;
				next_st.claim = 1'b1;
			end
			default: begin
				next_st.ack = 1'b0;
				next_st.claim = 1'b0;
			end
		endcase
		// parity path masked by override; registered for clean nmi timing
		next_st.parity_nmi = !i_parity_err_n && !sysp[SP_PAR_OVR];
		// extended page range only answers while enabled
		next_st.ext_hit = hit_ext && strobe && dmar[DM_EXT_PAGE];
		// configuration outputs lag the register write by one flop
		next_st.clock_sel = clkr[3:0];
		next_st.post = sysp[SP_POST];
		next_st.dec16 = sysp[SP_DEC16];
		next_st.scp_en = sysp[SP_SCP_EN];
		next_st.cyc_clocks = cycle_clocks(field2(sysp, SP_CYC_LO));
		next_st.std_present = copr[CP_STD];
		next_st.alt_present = copr[CP_ALT];
		next_st.dma_clk_inv = dmar[DM_CLK_INV];
		next_st.ext_en = dmar[DM_EXT_PAGE];
		next_st.wait_count = wait_states(field2(dmar, DM_WS_LO));
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			st <= reset_state();
		end else begin
			st <= next_st;
		end
	end

	// block bit read live, so a write to it governs the very next trigger
	icr_fpu_reset u_fpu_reset (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_trigger(fpu_trigger),
		.i_block(copr[CP_RST_BLK]),
		.o_fpu_reset_out(o_fpu_reset_out)
	);

	icr_hold_gate u_hold_gate (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_flow_enable(dmar[DM_FLOW]),
		.i_hold_ack(i_hold_ack),
		.i_local_ready_n(i_local_ready_n),
		.o_hold_ack_internal(o_hold_ack_internal)
	);

	assign o_io_rdata = st.rdata;
	assign o_io_ack = st.ack;
	assign o_io_claim = st.claim;
	assign o_parity_nmi_req = st.parity_nmi;
	assign o_ext_page_hit = st.ext_hit;
	assign o_clock_select = st.clock_sel;
	assign o_backplane_write_posting = st.post;
	assign o_decode_16bit = st.dec16;
	assign o_system_control_port_enable = st.scp_en;
	assign o_backplane_cycle_clocks = st.cyc_clocks;
	assign o_coproc_std_present = st.std_present;
	assign o_coproc_alt_present = st.alt_present;
	assign o_dma_clk_inverted = st.dma_clk_inv;
	assign o_ext_page_enable = st.ext_en;
	assign o_transfer_wait_count = st.wait_count;
endmodule : icr_config_regs

// File: icr_fpu_reset.sv
// module: software coprocessor reset pulse generator
`timescale 1ns/1ps
module icr_fpu_reset (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_trigger,
	input wire logic i_block,
	output logic o_fpu_reset_out
);
	import icr_pkg::*;
	typedef struct packed {
		logic [2:0] count;
		logic pulse;
	} icr_fr_state_t;
	icr_fr_state_t st;
	icr_fr_state_t next_st;
	always_comb begin
		next_st = st;
		if (i_trigger && !i_block) begin
			next_st.count = FPU_PULSE_CYCLES;
			next_st.pulse = 1'b1;
		end else if (st.count != 3'h0) begin
			next_st.count = st.count - 3'h1;
			next_st.pulse = (st.count != 3'h1);
		end else begin
			next_st.pulse = 1'b0;
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign o_fpu_reset_out = st.pulse;
endmodule : icr_fpu_reset

// File: icr_hold_gate.sv
// module: hold acknowledge gate waiting for write buffer empty
`timescale 1ns/1ps
module icr_hold_gate (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_flow_enable,
	input wire logic i_hold_ack,
	input wire logic i_local_ready_n,
	output logic o_hold_ack_internal
);
	import icr_pkg::*;
	typedef struct packed {
		icr_hs_state_t state;
		logic ack;
	} icr_hg_state_t;
	icr_hg_state_t st;
	icr_hg_state_t next_st;
	always_comb begin
		next_st = st;
		case (st.state)
			HS_IDLE: begin
				if (i_hold_ack) begin
					next_st.state = i_flow_enable ? HS_WAIT_READY : HS_GRANTED;
				end
			end
			HS_WAIT_READY: begin
				if (!i_hold_ack) begin
					next_st.state = HS_IDLE;
				end else if (!i_local_ready_n) begin
					next_st.state = HS_GRANTED;
				end
			end
			HS_GRANTED: begin
				if (!i_hold_ack) begin
					next_st.state = HS_IDLE;
				end
			end
			default: begin
				next_st.state = HS_IDLE;
			end
		endcase
		next_st.ack = (next_st.state == HS_GRANTED);
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			st <= '{state: HS_IDLE, ack: 1'b0};
		end else begin
			st <= next_st;
		end
	end
	assign o_hold_ack_internal = st.ack;
endmodule : icr_hold_gate

// File: icr_host.sv
// host model: i/o cycles on the configuration ports
`timescale 1ns/1ps
module icr_host (
	input wire logic i_clk,
	input wire logic i_io_ack,
	input wire logic [7:0] i_io_rdata,
	output logic [15:0] o_io_addr,
	output logic o_io_wr,
	output logic o_io_rd,
	output logic [7:0] o_io_wdata
);
	initial begin
		o_io_addr = 16'h0000;
		o_io_wr = 1'b0;
		o_io_rd = 1'b0;
		o_io_wdata = 8'h00;
	end
	// one-cycle strobe; answer is fixed one cycle later
	task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q, output logic k);
		@(negedge i_clk);
		o_io_addr = a;
		o_io_wr = w;
		o_io_rd = !w;
		o_io_wdata = d;
		@(negedge i_clk);
		o_io_wr = 1'b0;
		o_io_rd = 1'b0;
		// released lines flip so a stale value never passes for a live one
		o_io_addr = ~a;
		o_io_wdata = ~d;
		k = i_io_ack;
		q = i_io_rdata;
	endtask : cyc
endmodule : icr_host

// File: icr_pkg.sv
// package: constants and types of the indexed configuration register bank
package icr_pkg;
	localparam logic [15:0] PORT_DATA = 16'h0024;
	localparam logic [15:0] PORT_INDEX = 16'h0028;
	localparam logic [15:0] PORT_FPU_RESET = 16'h00f1;
	localparam logic [15:0] EXT_PAGE_BASE = 16'h0480;
	localparam logic [15:0] EXT_PAGE_LAST = 16'h048f;
	localparam logic [9:0] SHORT_DECODE_MASK = 10'h3ff;
	localparam logic [4:0] IDX_CHIP_ID = 5'h00;
	localparam logic [4:0] IDX_CLOCK = 5'h01;
	localparam logic [4:0] IDX_SYSPAR = 5'h02;
	localparam logic [4:0] IDX_COPROC = 5'h05;
	localparam logic [4:0] IDX_DMA = 5'h06;
	localparam int REG_COUNT = 32;
	// identification nibbles: values are arbitrary
	localparam logic [3:0] CHIP_REVISION = 4'h3;
	localparam logic [3:0] CHIP_CODE = 4'h5;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [4:0] RESET_INDEX = 5'h00;
	// system parameter bits
	localparam int SP_POST = 0;
	localparam int SP_DEC16 = 1;
	localparam int SP_SCP_EN = 2;
	localparam int SP_CYC_LO = 3;
	localparam int SP_PAR_OVR = 5;
	// coprocessor bits
	localparam int CP_STD = 0;
	localparam int CP_ALT = 1;
	localparam int CP_RST_BLK = 2;
	// dma bits
	localparam int DM_CLK_INV = 0;
	localparam int DM_EXT_PAGE = 1;
	localparam int DM_FLOW = 2;
	localparam int DM_WS_LO = 3;
	localparam logic [2:0] CYC_BASE = 3'h6;
	localparam logic [1:0] WS_BASE = 2'h3;
	localparam logic [2:0] FPU_PULSE_CYCLES = 3'h4;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_WAIT_READY = 2'b01,
		HS_GRANTED = 2'b10
	} icr_hs_state_t;
endpackage : icr_pkg

// File: tb.sv
// testbench: register bank driven through the host model
`timescale 1ns/1ps
module tb;
	import icr_pkg::*;
	logic i_clk, i_rst_b, i_hold_ack, i_local_ready_n, i_parity_err_n, w, r, ak, nmi, hi, fr, k;
	logic cl, eh;
	logic [15:0] a;
	logic [7:0] d, rq, q, v, pc;
	logic [3:0] cs;
	logic [2:0] sp, cc;
	logic [1:0] cp, dm, wc;
	int n_errors = 0, comparisons = 0, cyc_n = 0;
	localparam logic [3:0] CK [6] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
	icr_host icr_host_inst (.i_clk, .i_io_ack(ak), .i_io_rdata(rq), .o_io_addr(a), .o_io_wr(w),
		.o_io_rd(r), .o_io_wdata(d));
	icr_config_regs icr_config_regs_inst (.i_clk, .i_rst_b, .i_io_addr(a), .i_io_wr(w), .i_io_rd(r),
		.i_io_wdata(d), .i_hold_ack, .i_local_ready_n, .i_parity_err_n, .o_io_rdata(rq),
		.o_io_ack(ak), .o_io_claim(cl), .o_clock_select(cs), .o_backplane_write_posting(sp[0]),
		.o_decode_16bit(sp[1]), .o_system_control_port_enable(sp[2]), .o_backplane_cycle_clocks(cc),
		.o_parity_nmi_req(nmi), .o_coproc_std_present(cp[0]), .o_coproc_alt_present(cp[1]),
		.o_dma_clk_inverted(dm[0]), .o_ext_page_enable(dm[1]), .o_ext_page_hit(eh),
		.o_transfer_wait_count(wc), .o_hold_ack_internal(hi), .o_fpu_reset_out(fr));
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic io(input logic [15:0] ad, input logic wn, input logic [7:0] dd);
		icr_host_inst.cyc(ad, wn, dd, q, k);
	endtask : io
	task automatic wr_reg(input logic [4:0] i, input logic [7:0] dd);
		io(PORT_INDEX, 1'b1, {3'h0, i});
		io(PORT_DATA, 1'b1, dd);
		chk("data ack", 8'h01, {7'h0, k});
		chk("data claim", 8'h01, {7'h0, cl});
	endtask : wr_reg
	task automatic rd_io(input logic [15:0] ad, input logic [7:0] e);
		io(ad, 1'b0, 8'h00);
		chk("rdata", e, q);
	endtask : rd_io
	task automatic idle(input int c);
		repeat (c) @(negedge i_clk);
	endtask : idle
	task automatic pulses(input logic [7:0] e);
		pc = 8'h00;
		repeat (8) begin
			pc = pc + {7'h0, fr};
			idle(1);
		end
		chk("fpu pulse", e, pc);
	endtask : pulses
	task automatic wrap_up;
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// whole run is well under a thousand cycles
	always @(posedge i_clk) begin
		cyc_n++;
		if (cyc_n == 4000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		i_rst_b = 1'b0;
		i_hold_ack = 1'b0;
		i_local_ready_n = 1'b1;
		i_parity_err_n = 1'b1;
		idle(16);
		i_rst_b = 1'b1;
		rd_io(PORT_INDEX, 8'h00);
		rd_io(PORT_DATA, {CHIP_CODE, CHIP_REVISION});
		chk("cycle", 8'h06, {5'h0, cc});
		chk("ws", 8'h03, {6'h0, wc});
		wr_reg(IDX_CHIP_ID, 8'hff);
		rd_io(PORT_DATA, {CHIP_CODE, CHIP_REVISION});
		foreach (CK[j]) begin
			wr_reg(IDX_CLOCK, {4'h0, CK[j]});
			idle(2);
			chk("clock", {4'h0, CK[j]}, {4'h0, cs});
		end
		for (int j = 0; j < 4; j++) begin
			v = {3'h0, 2'(j), 3'(j * 3)};
			wr_reg(IDX_SYSPAR, v);
			wr_reg(IDX_DMA, v);
			idle(2);
			chk("sysparam", {5'h0, v[2:0]}, {5'h0, sp});
			chk("cycle", 8'(6 - j), {5'h0, cc});
			chk("dma", {6'h0, v[1:0]}, {6'h0, dm});
			chk("ws", 8'(3 - j), {6'h0, wc});
			io(16'h0485, 1'b0, 8'h00);
			chk("ext hit", {7'h0, v[1]}, {7'h0, eh});
		end
		for (int j = 7; j < 32; j++)
			wr_reg(5'(j), 8'(j * 37));
		for (int j = 7; j < 32; j++) begin
			io(PORT_INDEX, 1'b1, 8'(j));
			rd_io(PORT_DATA, 8'(j * 37));
			rd_io(PORT_DATA, 8'(j * 37));
		end
		rd_io(PORT_INDEX, 8'h1f);
		io(16'h0030, 1'b0, 8'h00);
		chk("unmapped ack", 8'h00, {7'h0, k});
		wr_reg(IDX_COPROC, 8'h03);
		idle(2);
		chk("coproc", 8'h03, {6'h0, cp});
		io(PORT_FPU_RESET, 1'b1, 8'h5a);
		pulses(8'h04);
		wr_reg(IDX_COPROC, 8'h04);
		io(PORT_FPU_RESET, 1'b1, 8'ha5);
		pulses(8'h00);
		i_parity_err_n = 1'b0;
		idle(2);
		chk("nmi", 8'h01, {7'h0, nmi});
		wr_reg(IDX_SYSPAR, 8'h20);
		idle(2);
		chk("nmi", 8'h00, {7'h0, nmi});
		io(16'h0428, 1'b0, 8'h00);
		chk("alias ack", 8'h01, {7'h0, k});
		chk("alias rdata", 8'h02, q);
		wr_reg(IDX_SYSPAR, 8'h22);
		io(16'h0428, 1'b0, 8'h00);
		chk("alias ack", 8'h00, {7'h0, k});
		i_hold_ack = 1'b1;
		idle(2);
		chk("hold", 8'h01, {7'h0, hi});
		i_hold_ack = 1'b0;
		wr_reg(IDX_DMA, 8'h04);
		i_hold_ack = 1'b1;
		idle(3);
		chk("hold", 8'h00, {7'h0, hi});
		i_local_ready_n = 1'b0;
		idle(2);
		chk("hold", 8'h01, {7'h0, hi});
		i_hold_ack = 1'b0;
		idle(2);
		chk("hold", 8'h00, {7'h0, hi});
		wrap_up();
	end
endmodule : tb
